// >>> design/oag_pkg.sv
// operand address generator package: modes, fixed address parts, widths
// assumes an 8-bit core with a 16-bit address space
package oag_pkg;

    // addressing modes, one-hot
    typedef enum logic [9:0] {
        OAG_DIRECT   = 10'h001,
        OAG_EXTENDED = 10'h002,
        OAG_BITDIR   = 10'h004,
        OAG_INDEX    = 10'h008,
        OAG_POINTER  = 10'h010,
        OAG_GENREG   = 10'h020,
        OAG_IMMED    = 10'h040,
        OAG_VECTOR   = 10'h080,
        OAG_RELATIVE = 10'h100,
        OAG_INHERENT = 10'h200
    } oag_mode_t;

    // fixed address parts and counts
    localparam logic [7:0]  OAG_PAGE0_HIGH   = 8'h00;
    localparam logic [7:0]  OAG_REGBANK_HIGH = 8'h01;
    localparam logic [15:0] OAG_VECTOR_BASE  = 16'hffc0;
    localparam int          OAG_MODE_COUNT   = 10;
    localparam int          OAG_OPCODE_COUNT = 256;
    localparam int          OAG_DEFINED_OPS  = 140;
    localparam int          OAG_REG_COUNT    = 8;

    // opcode fields
    localparam int OAG_LOW3_LSB = 0;
    localparam int OAG_LOW3_W   = 3;

    // sequencer states, one-hot
    typedef enum logic [3:0] {
        OAG_IDLE  = 4'h1,
        OAG_READ  = 4'h2,
        OAG_WRITE = 4'h4,
        OAG_VECLO = 4'h8
    } oag_state_t;

    // reset values of outputs
    localparam logic [15:0] OAG_ADDR_RST = 16'h0000;
    localparam logic [7:0]  OAG_DATA_RST = 8'h00;

endpackage

// >>> design/oag_ea_calc.sv
// operand address generator: combinational effective-address former
// assumes operands are already gathered by fetch logic and held stable
`timescale 1ns/10ps
module oag_ea_calc
    import oag_pkg::*;
(
    // decoded request
    input  wire oag_mode_t   mode,
    input  wire logic [7:0]  opcode,
    input  wire logic [7:0]  operand0,
    input  wire logic [7:0]  operand1,
    // core registers
    input  wire logic [15:0] index_register,
    input  wire logic [15:0] extra_pointer,
    input  wire logic [4:0]  register_bank_pointer,
    input  wire logic [15:0] program_counter,
    // results
    output logic [15:0]      ea,
    output logic [2:0]       bit_pos,
    output logic             ea_valid
);

    logic [2:0]  low3;
    logic [15:0] disp_ext;

    assign low3     = opcode[OAG_LOW3_LSB +: OAG_LOW3_W];
    assign disp_ext = {{8{operand0[7]}}, operand0};
    assign bit_pos  = low3;

    // address per mode; carries beyond bit 15 drop by width
    always_comb begin
        ea       = OAG_ADDR_RST;
        ea_valid = 1'b1;
        case (mode)
            OAG_DIRECT:   ea = {OAG_PAGE0_HIGH, operand0};
            OAG_EXTENDED: ea = {operand0, operand1};
            OAG_BITDIR:   ea = {OAG_PAGE0_HIGH, operand0};
            OAG_INDEX:    ea = index_register + disp_ext;
            OAG_POINTER:  ea = extra_pointer;
            OAG_GENREG:   ea = {OAG_REGBANK_HIGH, register_bank_pointer, low3};
            OAG_VECTOR:   ea = OAG_VECTOR_BASE + {12'h000, low3, 1'b0};
            OAG_RELATIVE: ea = program_counter + disp_ext;
            default:      ea_valid = 1'b0; // immediate, inherent: no address
        endcase
    end

endmodule

// >>> design/oag_top.sv
// operand address generator top: mode decode, address, bit rmw, vector fetch
// assumes opcode and operand bytes held stable while start is pulsed;
// memory answers reads one cycle after mem_rd (mem_rdata valid then)
`timescale 1ns/10ps
module oag_top
    import oag_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // decoded instruction
    input  wire logic        start,
    input  wire logic [9:0]  mode_sel,
    input  wire logic [7:0]  opcode,
    input  wire logic [7:0]  operand0,
    input  wire logic [7:0]  operand1,
    input  wire logic        word_op,
    input  wire logic        bit_op,
    input  wire logic        bit_value,
    input  wire logic        defined_op,
    // core registers
    input  wire logic [15:0] index_register,
    input  wire logic [15:0] extra_pointer,
    input  wire logic [4:0]  register_bank_pointer,
    input  wire logic [15:0] program_counter,
    input  wire logic [15:0] accumulator,
    // memory bus
    input  wire logic [7:0]  mem_rdata,
    output logic [15:0]      mem_addr,
    output logic             mem_rd,
    output logic             mem_wr,
    output logic [7:0]       mem_wdata,
    // results
    output logic [15:0]      ea_out,
    output logic [2:0]       bit_pos_out,
    output logic [15:0]      imm_out,
    output logic [15:0]      target_out,
    output logic [7:0]       accumulator_high,
    output logic [7:0]       accumulator_low,
    output logic             done,
    output logic             bad_op
);

    oag_mode_t   mode;
    oag_state_t  state_reg;
    oag_state_t  state_next;
    logic [15:0] ea;
    logic [2:0]  bit_pos;
    logic        ea_valid;
    logic [2:0]  bit_reg;
    logic        val_reg;
    logic        vec_reg;
    logic [7:0]  vec_hi_reg;
    logic        vec_fin_reg;
    logic        take_req;
    logic [7:0]  bit_mask;

    // only legal one-hot codes give an address; others act as inherent
    assign mode = oag_mode_t'(mode_sel);

    // a request is taken only while idle; starts inside a sequence are ignored
    assign take_req = (state_reg == OAG_IDLE) && start;

    oag_ea_calc u_calc (
        .mode                  (mode),
        .opcode                (opcode),
        .operand0              (operand0),
        .operand1              (operand1),
        .index_register        (index_register),
        .extra_pointer         (extra_pointer),
        .register_bank_pointer (register_bank_pointer),
        .program_counter       (program_counter),
        .ea                    (ea),
        .bit_pos               (bit_pos),
        .ea_valid              (ea_valid)
    );

    // one-hot mask of the bit to alter; the other seven bits pass untouched
    for (genvar i = 0; i < 8; i++) begin : g_mask
        assign bit_mask[i] = (bit_reg == 3'(i));
    end

    // pure bit modify used by the write-back step
    function automatic logic [7:0] oag_set_bit(input logic [7:0] d, input logic [7:0] m, input logic v);
        return v ? (d | m) : (d & ~m);
    endfunction

    // sequencer: idle, read strobe, data wait then write, two vector cycles
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            OAG_IDLE: begin
                if (start && defined_op && bit_op && ea_valid)
                    state_next = OAG_READ;
                else if (start && defined_op && mode == OAG_VECTOR)
                    state_next = OAG_READ;
            end
            OAG_READ: begin
                state_next = vec_reg ? OAG_VECLO : OAG_WRITE;
            end
            OAG_WRITE: state_next = OAG_IDLE;
            OAG_VECLO: state_next = vec_fin_reg ? OAG_IDLE : OAG_VECLO; // low byte lands in second cycle
            default:   state_next = OAG_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst)
            state_reg <= OAG_IDLE;
        else
            state_reg <= state_next;
    end

    // request capture: bit position for the write-back
    always_ff @(posedge clock) begin
        if (sys_rst)
            bit_reg <= 3'h0;
        else if (take_req)
            bit_reg <= bit_pos;
    end

    // request capture: new bit value, set or clear
    always_ff @(posedge clock) begin
        if (sys_rst)
            val_reg <= 1'b0;
        else if (take_req)
            val_reg <= bit_value;
    end

    // request capture: vector flag steers the read state
    always_ff @(posedge clock) begin
        if (sys_rst)
            vec_reg <= 1'b0;
        else if (take_req)
            vec_reg <= (mode == OAG_VECTOR);
    end

    // read strobe and address; rmw keeps the address for its write-back
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            mem_addr <= OAG_ADDR_RST;
            mem_rd   <= 1'b0;
        end else begin
            mem_rd <= 1'b0;
            if (state_next == OAG_READ) begin
                mem_addr <= ea;
                mem_rd   <= 1'b1;
            end else if (state_reg == OAG_READ && vec_reg) begin
                mem_addr <= mem_addr + 16'h0001;
                mem_rd   <= 1'b1;
            end
        end
    end

    // write strobe at the end of the wait state: read data only stands
    // the cycle after the read strobe, so an earlier write would use stale data
    always_ff @(posedge clock) begin
        if (sys_rst)
            mem_wr <= 1'b0;
        else
            mem_wr <= (state_reg == OAG_WRITE);
    end

    // write-back byte: read value with only the chosen bit altered
    always_ff @(posedge clock) begin
        if (sys_rst)
            mem_wdata <= OAG_DATA_RST;
        else if (state_reg == OAG_WRITE)
            mem_wdata <= oag_set_bit(mem_rdata, bit_mask, val_reg);
    end

    // vector cycle marker: first cycle takes the high byte, second the low byte
    always_ff @(posedge clock) begin
        if (sys_rst)
            vec_fin_reg <= 1'b0;
        else
            vec_fin_reg <= (state_reg == OAG_VECLO) && !vec_fin_reg;
    end

    // vector high byte (lower address) held until the low byte arrives
    always_ff @(posedge clock) begin
        if (sys_rst)
            vec_hi_reg <= OAG_DATA_RST;
        else if (state_reg == OAG_VECLO && !vec_fin_reg)
            vec_hi_reg <= mem_rdata;
    end

    // effective address and bit number of a request, one cycle after start
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ea_out      <= OAG_ADDR_RST;
            bit_pos_out <= 3'h0;
        end else if (take_req) begin
            ea_out      <= ea;
            bit_pos_out <= bit_pos;
        end
    end

    // undefined opcodes are flagged and start no bus sequence
    always_ff @(posedge clock) begin
        if (sys_rst)
            bad_op <= 1'b0;
        else if (take_req)
            bad_op <= !defined_op;
    end

    // immediate bytes pass straight through; byte form zero-extends
    always_ff @(posedge clock) begin
        if (sys_rst)
            imm_out <= OAG_ADDR_RST;
        else if (take_req && mode == OAG_IMMED)
            imm_out <= word_op ? {operand0, operand1} : {8'h00, operand0};
    end

    // branch target: relative at once, vector once both bytes are in
    always_ff @(posedge clock) begin
        if (sys_rst)
            target_out <= OAG_ADDR_RST;
        else if (take_req && mode == OAG_RELATIVE)
            target_out <= ea;
        else if (state_reg == OAG_VECLO && vec_fin_reg)
            target_out <= {vec_hi_reg, mem_rdata};
    end

    // accumulator high half, one cycle behind the core register
    always_ff @(posedge clock) begin
        if (sys_rst)
            accumulator_high <= OAG_DATA_RST;
        else
            accumulator_high <= accumulator[15:8];
    end

    // accumulator low half, one cycle behind the core register
    always_ff @(posedge clock) begin
        if (sys_rst)
            accumulator_low <= OAG_DATA_RST;
        else
            accumulator_low <= accumulator[7:0];
    end

    // done one cycle after start for plain requests, at end for sequences
    always_ff @(posedge clock) begin
        if (sys_rst)
            done <= 1'b0;
        else
            done <= (take_req && state_next == OAG_IDLE)
                 || state_reg == OAG_WRITE
                 || (state_reg == OAG_VECLO && vec_fin_reg);
    end

endmodule

// >>> bench/oag_checker.sv
// checker: address, strobe and result relations at the generator ports
// assumes start only while idle, inputs held until done
`timescale 1ns/10ps
module oag_checker
    import oag_pkg::*;
(
    // clock, reset, request
    input logic        clock,
    input logic        sys_rst,
    input logic        start,
    input logic        defined_op,
    input logic        bit_op,
    input logic        word_op,
    input logic [9:0]  mode_sel,
    input logic [7:0]  opcode,
    input logic [7:0]  operand0,
    input logic [7:0]  operand1,
    // core registers
    input logic [15:0] index_register,
    input logic [15:0] extra_pointer,
    input logic [15:0] program_counter,
    input logic [4:0]  register_bank_pointer,
    // outputs
    input logic [15:0] mem_addr,
    input logic [15:0] ea_out,
    input logic [15:0] imm_out,
    input logic [15:0] target_out,
    input logic        mem_rd,
    input logic        mem_wr,
    input logic        done,
    input logic        bad_op,
    input logic [2:0]  bit_pos_out
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // plain requests answer on the next edge
    wire        go = start && defined_op && !bit_op;
    wire [15:0] dx = {{8{operand0[7]}}, operand0};
    wire [15:0] vb = OAG_VECTOR_BASE + {12'h000, opcode[2:0], 1'b0};
    a_direct_addr: assert property (go && mode_sel == OAG_DIRECT
        |=> done && ea_out == {8'h00, operand0}) else $error("direct address wrong");
    a_ext_addr: assert property (go && mode_sel == OAG_EXTENDED
        |=> done && ea_out == {operand0, operand1}) else $error("extended address wrong");
    a_bitdir_addr: assert property (go && mode_sel == OAG_BITDIR
        |=> ea_out == {8'h00, operand0} && bit_pos_out == opcode[2:0]) else $error("bit address wrong");
    a_index_wrap: assert property (go && mode_sel == OAG_INDEX
        |=> ea_out == index_register + dx) else $error("index address wrong");
    a_pointer_addr: assert property (go && mode_sel == OAG_POINTER
        |=> ea_out == extra_pointer) else $error("pointer address wrong");
    a_bank_addr: assert property (go && mode_sel == OAG_GENREG
        |=> ea_out == {8'h01, register_bank_pointer, opcode[2:0]}) else $error("bank address wrong");
    a_immed_word: assert property (go && mode_sel == OAG_IMMED && word_op
        |=> imm_out == {operand0, operand1}) else $error("immediate word wrong");
    a_rel_target: assert property (go && mode_sel == OAG_RELATIVE
        |=> target_out == program_counter + dx) else $error("relative target wrong");
    a_vector_fetch: assert property (start && defined_op && mode_sel == OAG_VECTOR
        |=> mem_rd && mem_addr == vb ##1 mem_rd && mem_addr == vb + 16'h0001) else $error("vector fetch wrong");
    a_rmw_order: assert property (start && defined_op && bit_op && mode_sel == OAG_DIRECT
        |=> mem_rd && !mem_wr ##1 !mem_rd && !mem_wr ##1 mem_wr && mem_addr == {8'h00, operand0} && done)
        else $error("rmw order wrong");
    a_vector_done: assert property (start && defined_op && mode_sel == OAG_VECTOR
        |=> !done ##1 !done ##1 !done ##1 done) else $error("vector done not in fourth cycle");
    a_undef_flag: assert property (start && !defined_op
        |=> bad_op && !mem_rd) else $error("undefined opcode not flagged");
    // main scenarios seen
    cover property (start && mode_sel == OAG_VECTOR);
    cover property (mem_wr);
    cover property (bad_op);
endmodule

// >>> bench/oag_mem_model.sv
// memory partner: read data one cycle after mem_rd, writes kept
// assumes one request a cycle; idle data shows the inverted last value
`timescale 1ns/10ps
module oag_mem_model (
    // memory bus
    input  logic        clock,
    input  logic [15:0] mem_addr,
    input  logic        mem_rd,
    input  logic        mem_wr,
    input  logic [7:0]  mem_wdata,
    output logic [7:0]  mem_rdata
);
    logic [7:0] mem [0:65535];
    // unwritten places give an address pattern, so stale data cannot pass
    initial begin
        mem_rdata = 8'h00;
        for (int a = 0; a < 65536; a++)
            mem[a] = a[15:8] ^ a[7:0] ^ 8'h5a;
    end
    // reads answer on the next edge; an idle bus shows the inverse of its last value
    always @(posedge clock) begin
        if (mem_wr === 1'b1)
            mem[mem_addr] <= mem_wdata;
        if (mem_rd === 1'b1)
            mem_rdata <= mem[mem_addr];
        else
            mem_rdata <= ~mem_rdata;
    end
endmodule

// >>> bench/tb.sv
// testbench: drives decoded requests, judges addresses, strobes, results
// assumes the memory partner answers reads one cycle after mem_rd
`timescale 1ns/10ps
bind oag_top oag_checker oag_checker_i (.clock, .sys_rst, .start, .defined_op, .bit_op, .word_op, .mode_sel,
    .opcode, .operand0, .operand1, .index_register, .extra_pointer, .program_counter, .register_bank_pointer,
    .mem_addr, .ea_out, .imm_out, .target_out, .mem_rd, .mem_wr, .done, .bad_op, .bit_pos_out);
module tb;
    import oag_pkg::*;
    logic        clock, sys_rst, start, word_op, bit_op, bit_value, defined_op, mem_rd, mem_wr, done, bad_op;
    logic [9:0]  mode_sel;
    logic [7:0]  opcode, operand0, operand1, mem_rdata, mem_wdata, accumulator_high, accumulator_low, wd;
    logic [15:0] index_register, extra_pointer, program_counter, accumulator, mem_addr, ea_out, imm_out;
    logic [15:0] target_out;
    logic [4:0]  register_bank_pointer;
    logic [2:0]  bit_pos_out;
    int          bad_count = 0;
    int          checks_done = 0;
    oag_top oag_top_i (.clock, .sys_rst, .start, .mode_sel, .opcode, .operand0, .operand1, .word_op, .bit_op,
        .bit_value, .defined_op, .index_register, .extra_pointer, .register_bank_pointer, .program_counter,
        .accumulator, .mem_rdata, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .ea_out, .bit_pos_out, .imm_out,
        .target_out, .accumulator_high, .accumulator_low, .done, .bad_op);
    oag_mem_model oag_mem_model_i (.clock, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata);
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    task automatic check(input logic [15:0] s, input logic [15:0] e);
        checks_done++;
        if (s !== e) begin
            bad_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    function automatic logic [7:0] pat(input logic [15:0] a);
        return a[15:8] ^ a[7:0] ^ 8'h5a;
    endfunction
    // one request, then a bounded wait for done, noting any write
    task automatic run(input logic [9:0] m, input logic [7:0] op, o0, o1);
        int n;
        @(negedge clock);
        mode_sel = m;
        opcode = op;
        operand0 = o0;
        operand1 = o1;
        start = 1'b1;
        @(negedge clock);
        start = 1'b0;
        n = 0;
        // the write strobe stands in the same cycle as done
        while (done !== 1'b1 && n < 20) begin
            @(negedge clock);
            if (mem_wr === 1'b1)
                wd = mem_wdata;
            n++;
        end
        check({15'h0000, done}, 16'h0001);
    endtask
    task automatic t_modes;
        run(OAG_DIRECT, 8'h60, 8'hc3, 8'h00);
        check(ea_out, 16'h00c3);
        run(OAG_EXTENDED, 8'h61, 8'hab, 8'hcd);
        check(ea_out, 16'habcd);
        run(OAG_BITDIR, 8'ha6, 8'h7e, 8'h00);
        check({ea_out[12:0], bit_pos_out}, 16'h03f6);
        run(OAG_INDEX, 8'h62, 8'h02, 8'h00);
        check(ea_out, 16'h0001);
        run(OAG_INDEX, 8'h62, 8'h80, 8'h00);
        check(ea_out, 16'hff7f);
        run(OAG_POINTER, 8'h63, 8'h55, 8'h00);
        check(ea_out, 16'hbeef);
        run(OAG_GENREG, 8'h6d, 8'h00, 8'h00);
        check(ea_out, 16'h01fd);
        $display("t_modes done");
    endtask
    task automatic t_data;
        run(OAG_IMMED, 8'h04, 8'h9c, 8'h11);
        check(imm_out, 16'h009c);
        word_op = 1'b1;
        run(OAG_IMMED, 8'he4, 8'h9c, 8'h11);
        check(imm_out, 16'h9c11);
        run(OAG_RELATIVE, 8'hfc, 8'h80, 8'h00);
        check(target_out, 16'hff85);
        run(OAG_INHERENT, 8'h00, 8'h00, 8'h00);
        $display("t_data done");
    endtask
    task automatic t_vector;
        logic [15:0] a;
        for (int v = 0; v < 8; v++) begin
            a = OAG_VECTOR_BASE + 16'(2 * v);
            run(OAG_VECTOR, {5'h1d, v[2:0]}, 8'h00, 8'h00);
            check(target_out, {pat(a), pat(a + 16'h0001)});
        end
        $display("t_vector done");
    endtask
    // bits chosen so that each write really changes the byte
    task automatic t_rmw;
        bit_op = 1'b1;
        bit_value = 1'b1;
        run(OAG_DIRECT, 8'ha0, 8'h34, 8'h00);
        check({8'h00, wd}, {8'h00, pat(16'h0034) | 8'h01});
        bit_value = 1'b0;
        run(OAG_DIRECT, 8'hb2, 8'h35, 8'h00);
        check({8'h00, wd}, {8'h00, pat(16'h0035) & 8'hfb});
        bit_value = 1'b1;
        run(OAG_DIRECT, 8'ha7, 8'h34, 8'h00);
        check({8'h00, wd}, {8'h00, pat(16'h0034) | 8'h81});
        bit_op = 1'b0;
        $display("t_rmw done");
    endtask
    task automatic t_misc;
        defined_op = 1'b0;
        @(negedge clock);
        start = 1'b1;
        @(negedge clock);
        start = 1'b0;
        @(negedge clock);
        check({15'h0000, bad_op}, 16'h0001);
        check({accumulator_high, accumulator_low}, 16'h3ac5);
        defined_op = 1'b1;
        $display("t_misc done");
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        {sys_rst, defined_op} = 2'b11;
        {start, word_op, bit_op, bit_value} = 4'h0;
        {mode_sel, opcode, operand0, operand1, wd} = 42'h0;
        index_register = 16'hffff;
        extra_pointer = 16'hbeef;
        register_bank_pointer = 5'h1f;
        program_counter = 16'h0005;
        accumulator = 16'h3ac5;
        repeat (6) @(negedge clock);
        sys_rst = 1'b0;
        t_modes();
        t_data();
        t_vector();
        t_rmw();
        t_misc();
        print_verdict();
    end
    // whole run needs about 83 cycles
    initial begin
        #200000;
        bad_count++;
        print_verdict();
    end
endmodule
